// ===== logic/dlsc_pkg.sv
// Constants and carrier types for the DAC load, soft clear and table pointer command block
package dlsc_pkg;

    // ************************************************************
    // Command bytes and word layout
    // ************************************************************
    localparam logic [7:0] CMD_DAC_LOAD   = 8'h66;
    localparam logic [7:0] CMD_SOFT_CLEAR = 8'h74;
    localparam logic [7:0] CMD_TABLE_PTR  = 8'h7A;

    localparam int BIT_CH2_TRANSFER = 1;
    localparam int BIT_CH1_TRANSFER = 0;
    localparam int BIT_FIRE         = 6;
    localparam int BIT_ARM          = 5;
    localparam int BIT_ALARM_CLEAR  = 4;
    localparam int BIT_CACHE_FLUSH  = 3;
    localparam int BIT_QUEUE_FLUSH  = 2;
    localparam int BIT_CH2_CLEAR    = 1;
    localparam int BIT_CH1_CLEAR    = 0;
    localparam int COUNT_MSB        = 15;
    localparam int COUNT_LSB        = 8;
    localparam int BASE_MSB         = 7;
    localparam int BASE_LSB         = 0;

    // ************************************************************
    // Widths, reset values and timing
    // ************************************************************
    localparam int          DAC_W          = 12;
    localparam int          TBL_W          = 8;
    localparam logic [11:0] DAC_RST        = 12'h000;
    localparam logic [7:0]  TBL_RST        = 8'h00;
    localparam logic [7:0]  TBL_TOP        = 8'hFF;
    localparam logic [7:0]  TBL_ONE        = 8'h01;
    localparam logic [8:0]  INIT_WORDS     = 9'h100;
    localparam logic [8:0]  INIT_ZERO      = 9'h000;
    localparam logic [8:0]  INIT_ONE       = 9'h001;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [15:0] data;
    } dlsc_cmd_t;

    typedef struct packed {
        logic              ch2_wr;
        logic              ch1_wr;
        logic [DAC_W-1:0]  code;
    } dlsc_dac_wr_t;

    typedef struct packed {
        logic [DAC_W-1:0] ch2;
        logic [DAC_W-1:0] ch1;
    } dlsc_dac_pair_t;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_ARMED = 3'b010,
        ST_INIT  = 3'b100
    } dlsc_state_t;

endpackage

// ===== logic/dlsc_core.sv
// DAC load, soft clear and table pointer command registers of the bias controller
// Overview of operation
// - D1 of load copies channel 2 input
// - D0 of load copies channel 1 input
// - Soft clear answers command byte 74h
// - Soft clear ignores data bits D15-D7
// - Full reset acts after the fire write
// - Full reset restores registers, oscillator keeps running
// - No deep power-down clear needed afterwards
// - Busy high during RAM init, then low
// - Alarm clear resets thresholds and alarm flags
// - Cache flush resets pointers and cached values
// - Next sample forced through lookup after flush
// - Queue flush resets FIFO pointers and contents
// - Channel 2 clear resets input and output
// - Channel 1 clear resets input and output
// - Bits D15-D8 give word count, reset zero
// - Bits D7-D0 give base address, reset zero
// - Load trigger answers 66h, low two bits
// - Table pointer setup answers command byte 7Ah
// - Zero word count aborts table transfer
// - Transfer stops at top of table
`timescale 1ns/1ps

module dlsc_core (
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire dlsc_pkg::dlsc_cmd_t      cmd,
    input  wire dlsc_pkg::dlsc_dac_wr_t   dac_wr,
    input  wire logic                     shut_wr,
    input  wire logic                     shut_deep_pd,
    input  wire logic                     shut_osc_pd,
    input  wire logic                     table_step,
    input  wire logic                     sample_done,
    output logic                          busy,
    output logic                          deep_power_down,
    output logic                          osc_run,
    output logic                          soft_reset,
    output logic                          alarm_clear,
    output logic                          cache_flush,
    output logic                          force_lookup,
    output logic                          queue_flush,
    output dlsc_pkg::dlsc_dac_pair_t      dac_in,
    output dlsc_pkg::dlsc_dac_pair_t      dac_out,
    output logic [dlsc_pkg::TBL_W-1:0]    table_word_count,
    output logic [dlsc_pkg::TBL_W-1:0]    table_base,
    output logic [dlsc_pkg::TBL_W-1:0]    table_addr,
    output logic                          table_active
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_meta_r;
    logic rst_n_r;

    // Two flops so release never lands mid-edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // ************************************************************
    // Command decode
    // ************************************************************
    // Write strobe for one command byte
    function automatic logic is_cmd(input dlsc_pkg::dlsc_cmd_t c, input logic [7:0] code);
        is_cmd = c.valid && (c.code == code);
    endfunction

    logic        wr_load;
    logic        wr_clear;
    logic        wr_ptr;
    logic [15:0] d;

    // Decode the three write-only registers
    always_comb begin
        wr_load  = is_cmd(cmd, dlsc_pkg::CMD_DAC_LOAD);
        wr_clear = is_cmd(cmd, dlsc_pkg::CMD_SOFT_CLEAR);
        wr_ptr   = is_cmd(cmd, dlsc_pkg::CMD_TABLE_PTR);
        d        = cmd.data;
    end

    // ************************************************************
    // Full reset sequencer and busy
    // ************************************************************
    dlsc_pkg::dlsc_state_t state_r;
    dlsc_pkg::dlsc_state_t state_nxt;
    logic [8:0]            init_cnt_r;
    logic [8:0]            init_cnt_nxt;
    logic                  busy_r;
    logic                  busy_nxt;
    logic                  srst_r;
    logic                  srst_nxt;
    logic                  dpd_r;
    logic                  dpd_nxt;
    logic                  osc_r;
    logic                  osc_nxt;
    logic                  fire_ok;

    // Arm/fire tracking; only D6 and D5 of the word matter here
    always_comb begin
        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        busy_nxt     = busy_r;
        srst_nxt     = 1'b0;
        dpd_nxt      = dpd_r;
        osc_nxt      = osc_r;
        // fire counts only as the next soft clear write after arm
        fire_ok      = wr_clear && (state_r == dlsc_pkg::ST_ARMED) &&
                       d[dlsc_pkg::BIT_FIRE] && !d[dlsc_pkg::BIT_ARM];
        if (shut_wr) begin
            dpd_nxt = shut_deep_pd;
        end
        // Oscillator wakes on the next command after power-down
        if (shut_wr && shut_osc_pd) begin
            osc_nxt = 1'b0;
        end else if (cmd.valid) begin
            osc_nxt = 1'b1;
        end
        unique case (state_r)
            dlsc_pkg::ST_RUN, dlsc_pkg::ST_ARMED: begin
                if (fire_ok) begin
                    // act once the fire write is complete
                    state_nxt    = dlsc_pkg::ST_INIT;
                    srst_nxt     = 1'b1;
                    busy_nxt     = 1'b1;
                    init_cnt_nxt = dlsc_pkg::INIT_WORDS;
                    dpd_nxt      = 1'b0;
                    osc_nxt      = 1'b1;
                end else if (wr_clear) begin
                    // arm word is fire low, arm high
                    state_nxt = (d[dlsc_pkg::BIT_ARM] && !d[dlsc_pkg::BIT_FIRE]) ?
                                dlsc_pkg::ST_ARMED : dlsc_pkg::ST_RUN;
                end
            end
            dlsc_pkg::ST_INIT: begin
                // drop busy when the last word is done
                if (init_cnt_r == dlsc_pkg::INIT_ONE) begin
                    busy_nxt  = 1'b0;
                    state_nxt = dlsc_pkg::ST_RUN;
                end
                init_cnt_nxt = init_cnt_r - dlsc_pkg::INIT_ONE;
            end
            default: begin
                state_nxt = dlsc_pkg::ST_RUN;
            end
        endcase
    end

    // Power-on puts deep power-down high, unlike the soft reset
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r    <= dlsc_pkg::ST_RUN;
            init_cnt_r <= dlsc_pkg::INIT_ZERO;
            busy_r     <= 1'b0;
            srst_r     <= 1'b0;
            dpd_r      <= 1'b1;
            osc_r      <= 1'b1;
        end else begin
            state_r    <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            busy_r     <= busy_nxt;
            srst_r     <= srst_nxt;
            dpd_r      <= dpd_nxt;
            osc_r      <= osc_nxt;
        end
    end

    // ************************************************************
    // Clear strobes and forced lookup
    // ************************************************************
    logic alarm_r;
    logic alarm_nxt;
    logic cache_r;
    logic cache_nxt;
    logic queue_r;
    logic queue_nxt;
    logic force_r;
    logic force_nxt;

    // D15-D7 never looked at; an armed fire word does a full reset and no strobes
    always_comb begin
        alarm_nxt = wr_clear && !fire_ok && d[dlsc_pkg::BIT_ALARM_CLEAR];
        cache_nxt = wr_clear && !fire_ok && d[dlsc_pkg::BIT_CACHE_FLUSH];
        queue_nxt = wr_clear && !fire_ok && d[dlsc_pkg::BIT_QUEUE_FLUSH];
        // force next lookup; a new flush beats sample_done
        if (cache_nxt || srst_nxt) begin
            force_nxt = 1'b1;
        end else if (sample_done) begin
            force_nxt = 1'b0;
        end else begin
            force_nxt = force_r;
        end
    end

    // One-cycle strobes to the alarm, lookup and FIFO blocks; force flag held until sample_done
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            alarm_r <= 1'b0;
            cache_r <= 1'b0;
            queue_r <= 1'b0;
            force_r <= 1'b1;
        end else begin
            alarm_r <= alarm_nxt;
            cache_r <= cache_nxt;
            queue_r <= queue_nxt;
            force_r <= force_nxt;
        end
    end

    // ************************************************************
    // DAC input and output registers
    // ************************************************************
    dlsc_pkg::dlsc_dac_pair_t din_r;
    dlsc_pkg::dlsc_dac_pair_t din_nxt;
    dlsc_pkg::dlsc_dac_pair_t dout_r;
    dlsc_pkg::dlsc_dac_pair_t dout_nxt;

    // Clear beats load and new code; load copies the old input
    always_comb begin
        din_nxt  = din_r;
        dout_nxt = dout_r;
        if (dac_wr.ch2_wr) begin
            din_nxt.ch2 = dac_wr.code;
        end
        if (dac_wr.ch1_wr) begin
            din_nxt.ch1 = dac_wr.code;
        end
        if (wr_load) begin
            if (d[dlsc_pkg::BIT_CH2_TRANSFER]) begin
                dout_nxt.ch2 = din_r.ch2;
            end
            // channel 1 transfer, both may go
            if (d[dlsc_pkg::BIT_CH1_TRANSFER]) begin
                dout_nxt.ch1 = din_r.ch1;
            end
        end
        if (srst_nxt || (wr_clear && d[dlsc_pkg::BIT_CH2_CLEAR])) begin
            // channel 2 input and output cleared
            din_nxt.ch2  = dlsc_pkg::DAC_RST;
            dout_nxt.ch2 = dlsc_pkg::DAC_RST;
        end
        if (srst_nxt || (wr_clear && d[dlsc_pkg::BIT_CH1_CLEAR])) begin
            // channel 1 input and output cleared
            din_nxt.ch1  = dlsc_pkg::DAC_RST;
            dout_nxt.ch1 = dlsc_pkg::DAC_RST;
        end
    end

    // DAC code registers
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            din_r  <= {dlsc_pkg::DAC_RST, dlsc_pkg::DAC_RST};
            dout_r <= {dlsc_pkg::DAC_RST, dlsc_pkg::DAC_RST};
        end else begin
            din_r  <= din_nxt;
            dout_r <= dout_nxt;
        end
    end

    // ************************************************************
    // Table pointer setup and transfer walk
    // ************************************************************
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] base_r;
    logic [7:0] base_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [7:0] left_r;
    logic [7:0] left_nxt;
    logic       act_r;
    logic       act_nxt;

    // Address walks up one word per data access
    always_comb begin
        cnt_nxt  = cnt_r;
        base_nxt = base_r;
        addr_nxt = addr_r;
        left_nxt = left_r;
        act_nxt  = act_r;
        if (srst_nxt) begin
            cnt_nxt  = dlsc_pkg::TBL_RST;
            base_nxt = dlsc_pkg::TBL_RST;
            addr_nxt = dlsc_pkg::TBL_RST;
            left_nxt = dlsc_pkg::TBL_RST;
            act_nxt  = 1'b0;
        end else if (wr_ptr) begin
            cnt_nxt  = d[dlsc_pkg::COUNT_MSB:dlsc_pkg::COUNT_LSB];
            base_nxt = d[dlsc_pkg::BASE_MSB:dlsc_pkg::BASE_LSB];
            addr_nxt = d[dlsc_pkg::BASE_MSB:dlsc_pkg::BASE_LSB];
            left_nxt = d[dlsc_pkg::COUNT_MSB:dlsc_pkg::COUNT_LSB];
            act_nxt  = (d[dlsc_pkg::COUNT_MSB:dlsc_pkg::COUNT_LSB] != dlsc_pkg::TBL_RST);
        end else if (act_r && table_step) begin
            left_nxt = left_r - dlsc_pkg::TBL_ONE;
            // stop at top even with words left
            if ((left_r == dlsc_pkg::TBL_ONE) || (addr_r == dlsc_pkg::TBL_TOP)) begin
                act_nxt = 1'b0;
            end else begin
                addr_nxt = addr_r + dlsc_pkg::TBL_ONE;
            end
        end
    end

    // Table pointer state
    always_ff @(posedge clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cnt_r  <= dlsc_pkg::TBL_RST;
            base_r <= dlsc_pkg::TBL_RST;
            addr_r <= dlsc_pkg::TBL_RST;
            left_r <= dlsc_pkg::TBL_RST;
            act_r  <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            base_r <= base_nxt;
            addr_r <= addr_nxt;
            left_r <= left_nxt;
            act_r  <= act_nxt;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops
    // ************************************************************
    assign busy             = busy_r;
    assign deep_power_down  = dpd_r;
    assign osc_run          = osc_r;
    assign soft_reset       = srst_r;
    assign alarm_clear      = alarm_r;
    assign cache_flush      = cache_r;
    assign force_lookup     = force_r;
    assign queue_flush      = queue_r;
    assign dac_in           = din_r;
    assign dac_out          = dout_r;
    assign table_word_count = cnt_r;
    assign table_base       = base_r;
    assign table_addr       = addr_r;
    assign table_active     = act_r;

endmodule

// ===== test/dlsc_core_sva.sv
// Port checker for the DAC load, soft clear and table pointer block
`timescale 1ns/1ps

module dlsc_core_sva (
    input wire logic                     clk,
    input wire logic                     arst_n,
    input wire dlsc_pkg::dlsc_cmd_t      cmd,
    input wire logic                     busy,
    input wire logic                     deep_power_down,
    input wire logic                     osc_run,
    input wire logic                     soft_reset,
    input wire logic                     alarm_clear,
    input wire logic                     cache_flush,
    input wire logic                     force_lookup,
    input wire logic                     queue_flush,
    input wire dlsc_pkg::dlsc_dac_pair_t dac_in,
    input wire dlsc_pkg::dlsc_dac_pair_t dac_out,
    input wire logic [7:0]               table_word_count,
    input wire logic [7:0]               table_base,
    input wire logic                     table_active
);
    // ************************************************************
    // Helper decode and state
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic       sc;
    logic       ld;
    logic       tp;
    logic       fire;
    logic       armed_r;
    logic       armed_nxt;
    logic [9:0] busy_cnt_r;
    logic [9:0] busy_cnt_nxt;

    // Command decode, arm tracking and busy length
    always_comb begin
        sc = cmd.valid && (cmd.code == dlsc_pkg::CMD_SOFT_CLEAR);
        ld = cmd.valid && (cmd.code == dlsc_pkg::CMD_DAC_LOAD);
        tp = cmd.valid && (cmd.code == dlsc_pkg::CMD_TABLE_PTR);
        fire = sc && cmd.data[6] && !cmd.data[5];
        armed_nxt = armed_r;
        // Arm during init is not tracked, so mirror that
        if (sc) begin
            armed_nxt = cmd.data[5] && !cmd.data[6] && !busy;
        end
        busy_cnt_nxt = busy ? busy_cnt_r + 10'h001 : 10'h000;
    end

    // Helper registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_r <= 1'b0;
            busy_cnt_r <= 10'h000;
        end else begin
            armed_r <= armed_nxt;
            busy_cnt_r <= busy_cnt_nxt;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    load_ch2_a: assert property (ld && cmd.data[1] |=> dac_out.ch2 == $past(dac_in.ch2))
        else $error("channel 2 load wrong");
    load_ch1_a: assert property (ld && cmd.data[0] |=> dac_out.ch1 == $past(dac_in.ch1))
        else $error("channel 1 load wrong");
    fire_reset_a: assert property (fire && armed_r |=> soft_reset ##1 !soft_reset)
        else $error("armed fire gave no single reset pulse");
    reset_state_a: assert property (soft_reset |-> busy && !deep_power_down && osc_run && force_lookup
        && dac_out == 24'h00_0000 && table_word_count == 8'h00) else $error("soft reset state wrong");
    busy_len_a: assert property ($fell(busy) |-> busy_cnt_r == 10'h100)
        else $error("busy length wrong");
    alarm_pulse_a: assert property (sc && !cmd.data[6] && cmd.data[4] |=> alarm_clear)
        else $error("alarm clear missing");
    cache_pulse_a: assert property (sc && !cmd.data[6] && cmd.data[3] |=> cache_flush && force_lookup)
        else $error("cache flush missing");
    queue_pulse_a: assert property (sc && !cmd.data[6] && cmd.data[2] |=> queue_flush)
        else $error("queue flush missing");
    ch2_clear_a: assert property (sc && cmd.data[1] |=> dac_in.ch2 == 12'h000 && dac_out.ch2 == 12'h000)
        else $error("channel 2 clear wrong");
    ch1_clear_a: assert property (sc && cmd.data[0] |=> dac_in.ch1 == 12'h000 && dac_out.ch1 == 12'h000)
        else $error("channel 1 clear wrong");
    table_setup_a: assert property (tp |=> table_word_count == $past(cmd.data[15:8])
        && table_base == $past(cmd.data[7:0])) else $error("table setup fields wrong");
    count_abort_a: assert property (tp && cmd.data[15:8] == 8'h00 |=> !table_active)
        else $error("zero count did not abort");
    unarmed_fire_a: assert property (fire && !armed_r |=> !soft_reset)
        else $error("unarmed fire reset the block");

    // Main scenarios reached
    cover property (soft_reset);
    cover property ($fell(busy));
    cover property (fire && !armed_r);
endmodule

bind dlsc_core dlsc_core_sva u_sva (
    .clk(clk), .arst_n(arst_n), .cmd(cmd), .busy(busy), .deep_power_down(deep_power_down),
    .osc_run(osc_run), .soft_reset(soft_reset), .alarm_clear(alarm_clear), .cache_flush(cache_flush),
    .force_lookup(force_lookup), .queue_flush(queue_flush), .dac_in(dac_in), .dac_out(dac_out),
    .table_word_count(table_word_count), .table_base(table_base), .table_active(table_active)
);

// ===== test/dlsc_host_model.sv
// Host side model that issues command words to the block
`timescale 1ns/1ps

module dlsc_host_model (
    input wire logic          clk,
    output dlsc_pkg::dlsc_cmd_t cmd
);
    // ************************************************************
    // Command issue
    // ************************************************************
    initial cmd = '{valid: 1'b0, code: 8'h00, data: 16'h0000};

    task automatic send(input logic [7:0] code, input logic [15:0] data);
        @(negedge clk);
        cmd <= '{valid: 1'b1, code: code, data: data};
        @(negedge clk);
        // Idle word inverted so stale data is never mistaken for valid
        cmd <= '{valid: 1'b0, code: ~code, data: ~data};
    endtask

    task automatic full_reset();
        send(8'h74, 16'h0020);
        send(8'h74, 16'h0040);
    endtask
endmodule

// ===== test/tb_top.sv
// Self-checking testbench for the command block
`timescale 1ns/1ps

module tb_top;
    // ************************************************************
    // Stimulus signals and design
    // ************************************************************
    logic                     clk = 1'b0;
    logic                     arst_n = 1'b0;
    dlsc_pkg::dlsc_cmd_t      cmd;
    dlsc_pkg::dlsc_dac_wr_t   dac_wr = '0;
    logic                     table_step = 1'b0;
    logic                     sample_done = 1'b0;
    logic                     busy, deep_power_down, osc_run, soft_reset;
    logic                     alarm_clear, cache_flush, force_lookup, queue_flush, table_active;
    dlsc_pkg::dlsc_dac_pair_t dac_in, dac_out;
    logic [7:0]               table_word_count, table_base, table_addr;
    int                       n_fail = 0;
    int                       checks_done = 0;
    int                       n;

    always #12.5 clk = ~clk;

    dlsc_host_model u_host (.clk(clk), .cmd(cmd));

    // Shutdown inputs tied off: not part of this block's rules
    dlsc_core dut (
        .clk(clk), .arst_n(arst_n), .cmd(cmd), .dac_wr(dac_wr), .shut_wr(1'b0), .shut_deep_pd(1'b0),
        .shut_osc_pd(1'b0), .table_step(table_step), .sample_done(sample_done), .busy(busy),
        .deep_power_down(deep_power_down), .osc_run(osc_run), .soft_reset(soft_reset),
        .alarm_clear(alarm_clear), .cache_flush(cache_flush), .force_lookup(force_lookup),
        .queue_flush(queue_flush), .dac_in(dac_in), .dac_out(dac_out), .table_word_count(table_word_count),
        .table_base(table_base), .table_addr(table_addr), .table_active(table_active)
    );

    // ************************************************************
    // Helper tasks
    // ************************************************************
    // Wide enough for both 24-bit DAC register pairs together, 48 bits
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic dac_put(input logic ch2, input logic ch1, input logic [11:0] code);
        @(negedge clk);
        dac_wr <= '{ch2_wr: ch2, ch1_wr: ch1, code: code};
        @(negedge clk);
        dac_wr <= '0;
    endtask

    task automatic step(input bit done);
        @(negedge clk);
        if (done) begin
            sample_done <= 1'b1;
        end else begin
            table_step <= 1'b1;
        end
        @(negedge clk);
        sample_done <= 1'b0;
        table_step <= 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog: tests need well under 2000 cycles
    initial begin
        #100000;
        n_fail++;
        close_out();
    end

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("power_on", 6'b111000, {deep_power_down, osc_run, force_lookup, busy, table_active, soft_reset});
        chk("table_fields", 16'h0000, {table_word_count, table_base});
        $display("test reset done");

        u_host.full_reset();
        chk("soft_reset", 4'b1110, {soft_reset, busy, osc_run, deep_power_down});
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("busy_cycles", 256, n);
        $display("test full reset done");

        dac_put(1'b1, 1'b0, 12'h456);
        dac_put(1'b0, 1'b1, 12'h123);
        chk("dac_in", 24'h456_123, dac_in);
        u_host.send(8'h66, 16'hFFFE);
        chk("dac_out", 24'h456_000, dac_out);
        u_host.send(8'h66, 16'h0001);
        chk("dac_out", 24'h456_123, dac_out);
        u_host.send(8'h74, 16'h0082);
        chk("dac_pair", 48'h000_123_000_123, {dac_in, dac_out});
        u_host.send(8'h74, 16'h0001);
        chk("dac_pair", 48'h0, {dac_in, dac_out});
        $display("test dac load and clear done");

        step(1'b1);
        chk("force_lookup", 1'b0, force_lookup);
        for (int b = 2; b <= 4; b++) begin
            u_host.send(8'h74, 16'h0001 << b);
            chk("clear_pulses", 3'b001 << (b - 2), {alarm_clear, cache_flush, queue_flush});
        end
        chk("force_lookup", 1'b1, force_lookup);
        $display("test clear pulses done");

        u_host.send(8'h74, 16'h0040);
        chk("unarmed_fire", 2'b00, {soft_reset, busy});
        u_host.send(8'h74, 16'h0020);
        u_host.send(8'h74, 16'h0001);
        u_host.send(8'h74, 16'h0040);
        chk("disarmed_fire", 2'b00, {soft_reset, busy});
        $display("test unarmed fire done");

        u_host.send(8'h7A, 16'h0310);
        chk("table_setup", 25'h06_2021, {table_word_count, table_base, table_addr, table_active});
        repeat (3) step(1'b0);
        chk("table_end", 9'h024, {table_addr, table_active});
        u_host.send(8'h7A, 16'h05FE);
        step(1'b0);
        chk("table_near_top", 9'h1FF, {table_addr, table_active});
        step(1'b0);
        chk("table_top", 1'b0, table_active);
        u_host.send(8'h7A, 16'h0210);
        u_host.send(8'h7A, 16'h0010);
        chk("table_abort", 17'h0_0010 << 1, {table_word_count, table_base, table_active});
        $display("test table pointer done");
        close_out();
    end
endmodule
